// ---- src/scdi_top.sv ----
// Configuration registers and DAC smoothing interpolator.
// Assumes AXI4-Lite master and sample sources on mclk, DAC sink with ready.
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "scdi_params.svh"

// What this block does
// - Linear interpolation between consecutive 8 kHz samples
// - Each sample change split into 32 steps
// - Output bit 0 switches interpolator in analog
// - Temperature offset and gain in second channel
// - Configuration registers are 16-bit, software programmed
// - Front-end bit 8 enables burn-in mode
// - Front-end bits 7:6 select decimation rate
// - Front-end bits 1:0 pair axes to channels
// - Datapath bit 15 selects diagnostic level
// - Datapath bits 12:11 select angle modulo
// - Input gain equals setpoint gain times 2^exp
// - For variable setpoints, segment slope equals coefficient times 2^(exp+1)
// - Datapath bits 1:0 select setpoint scheme
// - Output bits 15:14 select primary protocol
module scdi_top #(
  parameter int STEP_CYCLES = `SCDI_STEP_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // AXI4-Lite write address and data
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Processed samples
  input wire logic sample_valid,
  input wire logic [15:0] sample_data,
  // Junction temperature in and scaled out
  input wire logic temp_valid,
  input wire logic [15:0] temp_data,
  output logic temp_out_valid,
  output logic [15:0] temp_out_data,
  // Segment slope coefficient in, slope out
  input wire logic [15:0] segment_slope_coefficient,
  output logic [31:0] segment_slope,
  // Effective linearizer input gain
  output logic [23:0] setpoint_gain_eff,
  // DAC stream
  output logic dac_valid,
  output logic [15:0] dac_data,
  input wire logic dac_ready,
  // Decoded configuration
  output logic burnin_en,
  output logic [1:0] decim_sel,
  output logic [1:0] axis_sel,
  output logic full_diag,
  output logic [1:0] modulo_sel,
  output logic setpoint_variable,
  output logic setpoint_differential,
  output logic [1:0] primary_output,
  output logic [15:0] supervision_out
);
  // Register storage
  logic [15:0] frontend_config_q; // Front-end word
  logic [15:0] datapath_config_q; // Datapath word
  logic [15:0] output_config_q; // Output word
  logic [15:0] supervision_config_q; // Supervision word
  logic [15:0] temp_offset_q; // Temperature offset
  logic [15:0] temp_gain_q; // Temperature gain, 0x4000 is unity
  logic [15:0] setpoint_input_gain_q; // Setpoint gain mantissa
  // Bus holding state
  logic aw_have_q; // Address captured
  logic w_have_q; // Data captured
  logic [7:0] aw_addr_q; // Captured address
  logic [31:0] w_data_q; // Captured data
  logic [3:0] w_strb_q; // Captured strobes
  logic [15:0] wval; // Merged write value
  logic [15:0] wcur; // Current value at write address
  logic wr_fire; // Both halves present
  // Interpolator state
  scdi_pkg::scdi_state_t state_q; // Sequencer
  logic [15:0] cur_q; // Latest sample target
  logic signed [16:0] delta_q; // Change over one sample period
  logic signed [21:0] acc_q; // Value scaled by 32
  logic signed [21:0] acc_nx; // Next accumulator value
  logic [5:0] step_q; // Steps emitted this period
  logic [15:0] timer_q; // Cycles between steps
  logic [15:0] word_q; // Word waiting for buffer
  logic interp_on; // Smoothing active
  logic analog_mode; // Analog primary output
  logic buf_ready; // Buffer can take a word
  logic push; // Word moves into buffer
  logic signed [31:0] temp_prod; // Temperature times gain

  // Merge byte strobes into the low half
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // Keep a two-bit field unless the new code is reserved
  function automatic logic [1:0] keep2(input logic [1:0] old, input logic [1:0] nw);
    keep2 = (nw == `SCDI_CODE_RESERVED) ? old : nw;
  endfunction

  // Current register value by address
  function automatic logic [15:0] regval(input logic [7:0] a, input logic [15:0] fe, input logic [15:0] dp,
                                         input logic [15:0] op, input logic [15:0] sv, input logic [15:0] to,
                                         input logic [15:0] tg, input logic [15:0] sg);
    case (a)
      `SCDI_OFF_FRONTEND: regval = fe;
      `SCDI_OFF_DATAPATH: regval = dp;
      `SCDI_OFF_OUTPUT: regval = op;
      `SCDI_OFF_SUPERVISION: regval = sv;
      `SCDI_OFF_TEMP_OFFSET: regval = to;
      `SCDI_OFF_TEMP_GAIN: regval = tg;
      `SCDI_OFF_SETPOINT_INPUT_GAIN: regval = sg;
      default: regval = 16'h0000;
    endcase
  endfunction

  // Address is a writable register
  function automatic logic writable(input logic [7:0] a);
    writable = (a == `SCDI_OFF_FRONTEND) || (a == `SCDI_OFF_DATAPATH) || (a == `SCDI_OFF_OUTPUT) ||
               (a == `SCDI_OFF_SUPERVISION) || (a == `SCDI_OFF_TEMP_OFFSET) ||
               (a == `SCDI_OFF_TEMP_GAIN) || (a == `SCDI_OFF_SETPOINT_INPUT_GAIN);
  endfunction

  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wcur = regval(aw_addr_q, frontend_config_q, datapath_config_q, output_config_q,
                       supervision_config_q, temp_offset_q, temp_gain_q, setpoint_input_gain_q);
  assign wval = merge(wcur, w_data_q, w_strb_q);

  // Write address and data capture, either order
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_have_q <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_have_q <= 1'b0;
      // Ready only while the slot is free and no response pends
      s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_have_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  // Write response, error for unmapped offsets and the read-only status word
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SCDI_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= writable(aw_addr_q) ? `SCDI_RESP_OKAY : `SCDI_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Register writes, 16-bit words with reserved bits held at zero
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      frontend_config_q <= `SCDI_RST_CFG;
      datapath_config_q <= `SCDI_RST_CFG;
      output_config_q <= `SCDI_RST_CFG;
      supervision_config_q <= `SCDI_RST_CFG;
      temp_offset_q <= `SCDI_RST_CFG;
      temp_gain_q <= `SCDI_RST_TEMP_GAIN;
      setpoint_input_gain_q <= `SCDI_RST_CFG;
    end
    else if (wr_fire)
    begin
      case (aw_addr_q)
        `SCDI_OFF_FRONTEND:
        begin
          // Burn-in bit, decimation and axis codes
          frontend_config_q <= wval & `SCDI_MASK_FRONTEND;
          frontend_config_q[`SCDI_FE_DECIM_HI:`SCDI_FE_DECIM_LO] <= keep2(
            frontend_config_q[`SCDI_FE_DECIM_HI:`SCDI_FE_DECIM_LO],
            wval[`SCDI_FE_DECIM_HI:`SCDI_FE_DECIM_LO]);
          frontend_config_q[`SCDI_FE_AXIS_HI:`SCDI_FE_AXIS_LO] <= keep2(
            frontend_config_q[`SCDI_FE_AXIS_HI:`SCDI_FE_AXIS_LO],
            wval[`SCDI_FE_AXIS_HI:`SCDI_FE_AXIS_LO]);
        end
        `SCDI_OFF_DATAPATH:
          datapath_config_q <= wval & `SCDI_MASK_DATAPATH;
        `SCDI_OFF_OUTPUT:
        begin
          // Reserved protocol codes are refused
          if (wval[`SCDI_OUT_PROT_HI] == 1'b0)
            output_config_q <= wval;
        end
        `SCDI_OFF_SUPERVISION:
          supervision_config_q <= wval;
        `SCDI_OFF_TEMP_OFFSET:
          temp_offset_q <= wval;
        `SCDI_OFF_TEMP_GAIN:
          temp_gain_q <= wval;
        `SCDI_OFF_SETPOINT_INPUT_GAIN:
          setpoint_input_gain_q <= wval;
        default:
          temp_offset_q <= temp_offset_q;
      endcase
    end
  end

  // Read channel, one cycle after address
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SCDI_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        if (s_axi_araddr == `SCDI_OFF_STATUS)
        begin
          // Live interpolator state and buffer fill
          s_axi_rdata <= {12'h000, !buf_ready, 3'(state_q), word_q};
          s_axi_rresp <= `SCDI_RESP_OKAY;
        end
        else
        begin
          s_axi_rdata <= {16'h0000, regval(s_axi_araddr, frontend_config_q, datapath_config_q,
                          output_config_q, supervision_config_q, temp_offset_q, temp_gain_q,
                          setpoint_input_gain_q)};
          s_axi_rresp <= writable(s_axi_araddr) ? `SCDI_RESP_OKAY : `SCDI_RESP_SLVERR;
        end
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Mode decode for the DAC path
  assign analog_mode = output_config_q[`SCDI_OUT_PROT_HI:`SCDI_OUT_PROT_LO] == `SCDI_PROT_ANALOG;
  assign interp_on = analog_mode && output_config_q[`SCDI_OUT_INTERP];
  assign acc_nx = acc_q + 22'(delta_q);
  assign push = (state_q == scdi_pkg::ST_PUSH) && buf_ready && analog_mode;

  // Interpolation sequencer; a new sample restarts from the last target
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= scdi_pkg::ST_IDLE;
      cur_q <= 16'h0000;
      delta_q <= 17'h00000;
      acc_q <= 22'h000000;
      step_q <= 6'h00;
      timer_q <= 16'h0000;
      word_q <= 16'h0000;
    end
    else if (sample_valid)
    begin
      cur_q <= sample_data;
      delta_q <= $signed({sample_data[15], sample_data}) - $signed({cur_q[15], cur_q});
      acc_q <= {{1{cur_q[15]}}, cur_q, 5'h00};
      step_q <= 6'h00;
      timer_q <= 16'h0000;
      if (interp_on)
        state_q <= scdi_pkg::ST_STEP;
      else
      begin
        word_q <= sample_data;
        state_q <= scdi_pkg::ST_PUSH;
      end
    end
    else
    begin
      case (state_q)
        scdi_pkg::ST_IDLE:
          state_q <= scdi_pkg::ST_IDLE;
        scdi_pkg::ST_STEP:
        begin
          // One step after STEP_CYCLES cycles in this state
          if (timer_q == 16'(STEP_CYCLES - 1))
          begin
            timer_q <= 16'h0000;
            acc_q <= acc_nx;
            word_q <= acc_nx[`SCDI_STEP_SHIFT + 15:`SCDI_STEP_SHIFT];
            step_q <= step_q + 6'h01;
            state_q <= scdi_pkg::ST_PUSH;
          end
          else
            timer_q <= timer_q + 16'h0001;
        end
        scdi_pkg::ST_PUSH:
        begin
          // Stall here while the buffer is full; drop word outside analog
          if (push || !analog_mode)
          begin
            if (interp_on && step_q != 6'(`SCDI_STEPS))
              state_q <= scdi_pkg::ST_STEP;
            else
              state_q <= scdi_pkg::ST_IDLE;
          end
        end
        default:
          state_q <= scdi_pkg::ST_IDLE;
      endcase
    end
  end

  // Two-entry buffer in front of the DAC
  scdi_skid #(
    .WIDTH(16)
  ) u_skid (
    .mclk(mclk),
    .reset_n(reset_n),
    .in_valid(push),
    .in_data(word_q),
    .in_ready(buf_ready),
    .out_valid(dac_valid),
    .out_data(dac_data),
    .out_ready(dac_ready)
  );

  assign temp_prod = $signed(temp_data) * $signed({1'b0, temp_gain_q[14:0]});

  // Temperature scaling for the second fast channel
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      temp_out_valid <= 1'b0;
      temp_out_data <= 16'h0000;
    end
    else
    begin
      temp_out_valid <= temp_valid;
      if (temp_valid)
      begin
        if (!analog_mode && output_config_q[`SCDI_OUT_SECONDARY])
          temp_out_data <= 16'(temp_prod >>> `SCDI_TEMP_GAIN_SHIFT) + temp_offset_q;
        else
          temp_out_data <= temp_data;
      end
    end
  end

  // Registered decode of configuration fields
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      burnin_en <= 1'b0;
      decim_sel <= 2'h0;
      axis_sel <= 2'h0;
      full_diag <= 1'b0;
      modulo_sel <= 2'h0;
      setpoint_variable <= 1'b0;
      setpoint_differential <= 1'b0;
      primary_output <= 2'h0;
      supervision_out <= 16'h0000;
      setpoint_gain_eff <= 24'h000000;
      segment_slope <= 32'h00000000;
    end
    else
    begin
      burnin_en <= frontend_config_q[`SCDI_FE_BURNIN];
      decim_sel <= frontend_config_q[`SCDI_FE_DECIM_HI:`SCDI_FE_DECIM_LO];
      axis_sel <= frontend_config_q[`SCDI_FE_AXIS_HI:`SCDI_FE_AXIS_LO];
      full_diag <= datapath_config_q[`SCDI_DP_FULLDIAG];
      modulo_sel <= datapath_config_q[`SCDI_DP_MOD_HI:`SCDI_DP_MOD_LO];
      setpoint_variable <= datapath_config_q[`SCDI_DP_SP_HI];
      setpoint_differential <= datapath_config_q[`SCDI_DP_SP_LO];
      primary_output <= output_config_q[`SCDI_OUT_PROT_HI:`SCDI_OUT_PROT_LO];
      supervision_out <= supervision_config_q;
      // Gain shifted by its exponent
      setpoint_gain_eff <= {8'h00, setpoint_input_gain_q} <<
                           datapath_config_q[`SCDI_DP_NMULT_HI:`SCDI_DP_NMULT_LO];
      // Slope uses exponent plus one, variable setpoints only
      if (datapath_config_q[`SCDI_DP_SP_HI])
        segment_slope <= {16'h0000, segment_slope_coefficient} <<
                         (5'(datapath_config_q[`SCDI_DP_NSP_HI:`SCDI_DP_NSP_LO]) + 5'h01);
      else
        segment_slope <= 32'h00000000;
    end
  end
endmodule // scdi_top

// ---- src/scdi_params.svh ----
// Constants for the sensor configuration and DAC interpolator block.
// Assumes a single 40 MHz system clock; included by bare name.
`ifndef SCDI_PARAMS_SVH
`define SCDI_PARAMS_SVH
// Timing
`define SCDI_CLK_HZ 40000000
`define SCDI_SAMPLE_HZ 8000
`define SCDI_STEPS 32
`define SCDI_STEP_SHIFT 5
`define SCDI_SAMPLE_CYCLES (`SCDI_CLK_HZ / `SCDI_SAMPLE_HZ)
`define SCDI_STEP_CYCLES (`SCDI_SAMPLE_CYCLES / `SCDI_STEPS)
// Register byte offsets
`define SCDI_OFF_FRONTEND 8'h00
`define SCDI_OFF_DATAPATH 8'h04
`define SCDI_OFF_OUTPUT 8'h08
`define SCDI_OFF_SUPERVISION 8'h0c
`define SCDI_OFF_TEMP_OFFSET 8'h10
`define SCDI_OFF_TEMP_GAIN 8'h14
`define SCDI_OFF_STATUS 8'h18
`define SCDI_OFF_SETPOINT_INPUT_GAIN 8'h1c
// Writable bit masks, reserved bits read as zero
`define SCDI_MASK_FRONTEND 16'h01c3
`define SCDI_MASK_DATAPATH 16'h9f3f
`define SCDI_MASK_OUTPUT 16'hffff
// Field positions
`define SCDI_FE_BURNIN 8
`define SCDI_FE_DECIM_HI 7
`define SCDI_FE_DECIM_LO 6
`define SCDI_FE_AXIS_HI 1
`define SCDI_FE_AXIS_LO 0
`define SCDI_DP_FULLDIAG 15
`define SCDI_DP_MOD_HI 12
`define SCDI_DP_MOD_LO 11
`define SCDI_DP_NMULT_HI 10
`define SCDI_DP_NMULT_LO 8
`define SCDI_DP_NSP_HI 5
`define SCDI_DP_NSP_LO 2
`define SCDI_DP_SP_HI 1
`define SCDI_DP_SP_LO 0
`define SCDI_OUT_PROT_HI 15
`define SCDI_OUT_PROT_LO 14
`define SCDI_OUT_SECONDARY 12
`define SCDI_OUT_INTERP 0
// Codes and reset values
`define SCDI_CODE_RESERVED 2'h3
`define SCDI_PROT_ANALOG 2'h0
`define SCDI_PROT_SENT 2'h1
`define SCDI_RST_CFG 16'h0000
`define SCDI_RST_TEMP_GAIN 16'h4000
`define SCDI_TEMP_GAIN_SHIFT 14
`define SCDI_RESP_OKAY 2'h0
`define SCDI_RESP_SLVERR 2'h2
`endif

// ---- src/scdi_pkg.sv ----
// Types for the sensor configuration and DAC interpolator block.
// Assumes the constants header is compiled alongside.
package scdi_pkg;
  // Interpolator sequencing states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_STEP = 3'h2,
    ST_PUSH = 3'h4
  } scdi_state_t;
endpackage

// ---- src/scdi_skid.sv ----
// Two-entry valid/ready buffer in front of the DAC.
// Assumes both sides run on the same clock as the block.
`timescale 1ns/100ps
module scdi_skid #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Filling side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Draining side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  logic spare_valid_q; // Second entry occupied
  logic [WIDTH-1:0] spare_data_q; // Second entry word
  logic take; // Word accepted from source
  logic give; // Word handed to sink

  assign take = in_valid && in_ready;
  assign give = out_valid && out_ready;

  // Head entry, refilled from spare first
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      out_valid <= 1'b0;
      out_data <= '0;
    end
    else if (!out_valid || give)
    begin
      if (spare_valid_q)
      begin
        out_valid <= 1'b1;
        out_data <= spare_data_q;
      end
      else
      begin
        out_valid <= take;
        if (take)
          out_data <= in_data;
      end
    end
  end

  // Spare entry, filled only when head is stalled
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      spare_valid_q <= 1'b0;
      spare_data_q <= '0;
      in_ready <= 1'b0;
    end
    else
    begin
      if (spare_valid_q && (!out_valid || give))
        spare_valid_q <= 1'b0;
      else if (take && out_valid && !give)
      begin
        spare_valid_q <= 1'b1;
        spare_data_q <= in_data;
      end
      // Ready drops once both entries are held
      in_ready <= !(spare_valid_q && out_valid && !give) && !(take && out_valid && !give);
    end
  end
endmodule // scdi_skid

// ---- tb/scdi_top_asserts.sv ----
// Checker for the block.
// Assumes only the top module's ports; bound below.
`timescale 1ns/100ps
module scdi_top_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Register bus
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // Streams
  input wire logic temp_valid,
  input wire logic temp_out_valid,
  input wire logic dac_valid,
  input wire logic dac_ready,
  input wire logic [15:0] dac_data,
  // Decoded fields
  input wire logic [1:0] decim_sel,
  input wire logic [1:0] axis_sel,
  input wire logic [1:0] primary_output
);
  // One domain, one reset
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Read address taken
  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // Write answer waiting
  sequence s_b_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  a_read_answer: assert property (s_ar_take |=> s_axi_rvalid)
    else $error("read answer missing");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_resp_hold: assert property (s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_dac_hold: assert property (dac_valid && !dac_ready |=> dac_valid && $stable(dac_data))
    else $error("dac word lost");
  a_temp_answer: assert property (temp_valid |=> temp_out_valid)
    else $error("temperature answer missing");
  a_temp_cause: assert property (temp_out_valid |-> $past(temp_valid))
    else $error("temperature out without cause");
  a_decim_legal: assert property (decim_sel != 2'h3)
    else $error("reserved decimation held");
  a_axis_legal: assert property (axis_sel != 2'h3)
    else $error("reserved axis pair held");
  a_prot_legal: assert property (!primary_output[1])
    else $error("reserved protocol held");
endmodule // scdi_top_asserts

bind scdi_top scdi_top_asserts u_chk (.mclk, .reset_n, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .temp_valid, .temp_out_valid,
  .dac_valid, .dac_ready, .dac_data, .decim_sel, .axis_sel, .primary_output);

// ---- tb/scdi_dac_model.sv ----
// Behavioural DAC sink.
// Assumes the block's clock; bench drives stall.
`timescale 1ns/100ps
module scdi_dac_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Stream from the block
  input wire logic dac_valid,
  input wire logic [15:0] dac_data,
  output logic dac_ready,
  // Bench control
  input wire logic stall
);
  // Words taken, oldest first
  logic [15:0] words [$];
  // Ready drops one cycle after stall
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n) dac_ready <= 1'b0;
    else dac_ready <= !stall;
  // Capture at each handshake
  always @(posedge mclk)
    if (reset_n && dac_valid && dac_ready) words.push_back(dac_data);
endmodule // scdi_dac_model

// ---- tb/test_sensor_config_and_dac_interpolator.sv ----
// Self-checking bench for the block.
// Assumes design, DAC model and checker.
`timescale 1ns/100ps
module test_sensor_config_and_dac_interpolator;
  // Bench signals
  logic mclk, reset_n, stall, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, segment_slope;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp, decim_sel, axis_sel, modulo_sel, primary_output;
  logic sample_valid, temp_valid, temp_out_valid, dac_valid, dac_ready;
  logic [15:0] sample_data, temp_data, temp_out_data, dac_data, segment_slope_coefficient, supervision_out;
  logic [23:0] setpoint_gain_eff;
  logic burnin_en, full_diag, setpoint_variable, setpoint_differential;
  int err_total, check_count;
  // Short step keeps runs short
  scdi_top #(.STEP_CYCLES(4)) dut (.mclk, .reset_n, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .sample_valid, .sample_data, .temp_valid, .temp_data, .temp_out_valid, .temp_out_data,
    .segment_slope_coefficient, .segment_slope, .setpoint_gain_eff, .dac_valid, .dac_data, .dac_ready,
    .burnin_en, .decim_sel, .axis_sel, .full_diag, .modulo_sel, .setpoint_variable, .setpoint_differential,
    .primary_output, .supervision_out);
  // DAC on the far side
  scdi_dac_model dac (.mclk, .reset_n, .dac_valid, .dac_data, .dac_ready, .stall);
  // Compare and count
  task automatic chk(input string n, input logic [31:0] e, g);
    check_count++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  // Verdict, single exit
  task automatic tally_and_finish;
    if (err_total == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Write, AW and W together
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= {16'h0000, d};
    s_axi_bready <= 1'b1;
    while (!s_axi_bvalid)
    begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  // Read and compare
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    while (!s_axi_rvalid)
    begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk("rdata", e, s_axi_rdata);
  endtask
  // One sample pulse, then settle
  task automatic smp(input logic [15:0] d, input int w);
    @(posedge mclk);
    sample_valid <= 1'b1;
    sample_data <= d;
    @(posedge mclk);
    sample_valid <= 1'b0;
    repeat (w) @(posedge mclk);
  endtask
  // Temperature pulse and result
  task automatic tmp(input logic [15:0] d, e);
    @(posedge mclk);
    temp_valid <= 1'b1;
    temp_data <= d;
    @(posedge mclk);
    temp_valid <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("temp_out", e, temp_out_data);
  endtask
  // Reset values
  task automatic t_reset;
    rdc(8'h00, 0);
    rdc(8'h04, 0);
    rdc(8'h08, 0);
    rdc(8'h14, 32'h4000);
    wr(8'h0c, 16'h00a5);
    chk("superv", 16'h00a5, supervision_out);
  endtask
  // Front-end fields
  task automatic t_front;
    wr(8'h00, 16'hffff);
    rdc(8'h00, 32'h0100);
    chk("burnin", 1, burnin_en);
    for (int k = 0; k < 3; k++)
    begin
      wr(8'h00, {8'h00, k[1:0], 4'h0, k[1:0]});
      chk("decim", k, decim_sel);
      chk("axis", k, axis_sel);
    end
    wr(8'h00, 16'h00c3);
    chk("decim_kept", 2, decim_sel);
  endtask
  // Datapath codes and exponents
  task automatic t_path;
    logic [15:0] v;
    for (int k = 0; k < 4; k++)
    begin
      v = {k[0], 2'h0, k[1:0], 9'h000, k[1:0]};
      wr(8'h04, v);
      rdc(8'h04, {16'h0000, v});
      chk("modulo", k, modulo_sel);
      chk("diag", k[0], full_diag);
      chk("scheme", k, {setpoint_variable, setpoint_differential});
    end
    wr(8'h1c, 16'h0003);
    wr(8'h04, 16'h0300);
    chk("gain_eff", 24'h000018, setpoint_gain_eff);
    chk("slope_fixed", 0, segment_slope);
    wr(8'h04, 16'h000a);
    chk("slope", 32'h28, segment_slope);
  endtask
  // Refusals and protocol codes
  task automatic t_err;
    wr(8'h20, 16'h1234);
    chk("bresp_unmapped", 2'h2, rsp);
    wr(8'h18, 16'h1234);
    chk("bresp_status", 2'h2, rsp);
    rdc(8'h20, 0);
    chk("rresp", 2'h2, rsp);
    wr(8'h08, 16'h8000);
    rdc(8'h08, 0);
    wr(8'h08, 16'h4000);
    chk("protocol", 1, primary_output);
    dac.words.delete();
    smp(16'h1234, 40);
    chk("sent_words", 0, dac.words.size());
    // Temperature scaling
    wr(8'h10, 16'h0010);
    wr(8'h14, 16'h2000);
    tmp(16'h0100, 16'h0100);
    wr(8'h08, 16'h5000);
    tmp(16'h0100, 16'h0090);
  endtask
  // Interpolator off then on
  task automatic t_hold;
    wr(8'h08, 16'h0000);
    dac.words.delete();
    smp(16'h1000, 10);
    smp(16'h2000, 10);
    chk("hold_count", 2, dac.words.size());
    chk("hold_word", 16'h2000, dac.words[1]);
    // DAC stalls from the sample pulse, released mid-sequence
    wr(8'h08, 16'h0001);
    smp(16'h2000, 300);
    dac.words.delete();
    stall <= 1'b1;
    smp(16'h4000, 60);
    stall <= 1'b0;
    repeat (400) @(posedge mclk);
    chk("step_count", 32, dac.words.size());
    for (int k = 1; k <= 32; k++)
      chk("step_word", 16'h2000 + k * 16'h0100, dac.words[k-1]);
  endtask
  // Clock
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // Watchdog
  initial
  begin
    #500000;
    err_total++;
    tally_and_finish();
  end
  // Main sequence
  initial
  begin
    {reset_n, stall, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
    {sample_valid, temp_valid, s_axi_awaddr, s_axi_araddr, s_axi_wdata, sample_data, temp_data} = 0;
    s_axi_wstrb = 4'h3;
    segment_slope_coefficient = 16'h0005;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (2) @(posedge mclk);
    t_reset();
    t_front();
    t_path();
    t_err();
    t_hold();
    tally_and_finish();
  end
endmodule // test_sensor_config_and_dac_interpolator
